// ---- logic/cfs_clock_fault.v ----
// Purpose: clock fault status and oscillator control registers
// Assumes: Avalon-MM slave, fault inputs synchronous to clk_sys
// Notes:   every access answers after one wait cycle
`timescale 1ns/10ps
`include "cfs_defines.vh"
module cfs_clock_fault #(
	parameter TAP_W = 5
) (
	input  wire             clk_sys,
	input  wire             rst_b,
	input  wire             clk_en,
	input  wire [3:0]       avs_address,
	input  wire             avs_read,
	input  wire             avs_write,
	input  wire [31:0]      avs_writedata,
	output reg  [31:0]      avs_readdata,
	output reg              avs_waitrequest,
	input  wire             xtal1_fault,
	input  wire             xtal1_high_freq,
	input  wire             xtal2_fault,
	input  wire [TAP_W-1:0] digital_osc_tap,
	input  wire             lock_too_low,
	input  wire             lock_too_fast,
	input  wire             xtal1_selected,
	input  wire             xtal2_selected,
	input  wire             xtal1_in_use,
	input  wire             xtal2_in_use,
	input  wire             module_osc_request,
	output reg              xtal1_run,
	output reg              xtal2_run,
	output reg              xtal2_from_pin,
	output reg              subsystem_clock_en,
	output reg              module_osc_grant,
	output reg              power_up_clear,
	output reg              irq
);
	reg  [15:0] osc_ctrl;
	reg  [15:0] req_ctrl;
	reg  [15:0] irq_mask;
	reg         warn_en;
	reg         fast_rst_en;
	reg  [1:0]  lock_loss_history;
	reg         lock_too_fast_flag;
	reg         xtal2_fault_flag;
	reg         xtal1_high_freq_fault_flag;
	reg         xtal1_low_freq_fault_flag;
	reg         digital_osc_fault_flag;
	reg         rd_pending;
	wire        x1_run;
	wire        x2_run;
	wire        tap_fault;
	wire [1:0]  lock_loss_now;
	wire        osc_fault_summary_flag;
	wire [15:0] fault_word;
	wire [15:0] irq_status;
	wire        wr;
	wire [15:0] wdata;
	wire [15:0] fault_wr;
	wire        fault_hit;

	// merge a byte or word write into a 16-bit register
	function [15:0] merge;
		input [3:0]  idx;
		input [3:0]  word_idx;
		input [15:0] old;
		input [15:0] wd;
		input [15:0] wmask;
		reg   [15:0] upd;
		begin
			upd = old;
			if (idx == word_idx)
				upd = wd;
			else if (idx == word_idx + 4'h3 - word_idx + word_idx * 2)
				upd = {old[15:8], wd[7:0]};
			else if (idx == word_idx + 4'h4 - word_idx + word_idx * 2)
				upd = {wd[7:0], old[7:0]};
			merge = (upd & wmask) | (old & ~wmask);
		end
	endfunction

	// read a word or alias byte of a register
	function [15:0] pick;
		input [3:0]  idx;
		input [3:0]  word_idx;
		input [15:0] val;
		begin
			if (idx == word_idx)
				pick = val;
			else if (idx == 4'h3 + word_idx * 2)
				pick = {8'h00, val[7:0]};
			else
				pick = {8'h00, val[15:8]};
		end
	endfunction

	// a write lands only at the edge where the master sees waitrequest low
	assign wr    = avs_write && clk_en && !avs_waitrequest;
	assign wdata = avs_writedata[15:0];

	// tap at either end of its range counts as a fault
	assign tap_fault = (digital_osc_tap == {TAP_W{1'b0}}) ||
	                   (digital_osc_tap == {TAP_W{1'b1}});
	// range error overrides the live lock state
	assign lock_loss_now = digital_osc_fault_flag ? `CFS_LOCK_ERR :
	                       {lock_too_fast, lock_too_low};
	// summary flag, history adds in only when warnings are enabled
	assign osc_fault_summary_flag = xtal2_fault_flag ||
	        xtal1_high_freq_fault_flag || xtal1_low_freq_fault_flag ||
	        digital_osc_fault_flag ||
	        (warn_en && lock_loss_history != 2'h0);
	assign fault_word = {2'h0, warn_en, fast_rst_en, lock_loss_history,
	                     lock_loss_now, 3'h0, lock_too_fast_flag,
	                     xtal2_fault_flag, xtal1_high_freq_fault_flag,
	                     xtal1_low_freq_fault_flag,
	                     digital_osc_fault_flag};
	assign irq_status = {lock_loss_history, 9'h0, lock_too_fast_flag,
	                     xtal2_fault_flag, xtal1_high_freq_fault_flag,
	                     xtal1_low_freq_fault_flag, digital_osc_fault_flag};
	assign fault_hit = wr && (avs_address == `CFS_IDX_FAULT ||
	                          avs_address == `CFS_IDX_FAULT_L ||
	                          avs_address == `CFS_IDX_FAULT_H);
	// image of the fault register after the write, unwritten bits kept
	assign fault_wr = fault_hit ?
	        merge(avs_address, `CFS_IDX_FAULT, fault_word, wdata,
	              16'hffff) : fault_word;

	// xtal1 gate
	cfs_osc_gate u_xtal1 (
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.clk_en      (clk_en),
		.disable_bit (osc_ctrl[`CFS_B_XT1_OFF]),
		.bypass      (osc_ctrl[`CFS_B_XT1_BYP]),
		.selected    (xtal1_selected),
		.in_use      (xtal1_in_use),
		.osc_run     (x1_run)
	);
	// xtal2 gate
	cfs_osc_gate u_xtal2 (
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.clk_en      (clk_en),
		.disable_bit (osc_ctrl[`CFS_B_XT2_OFF]),
		.bypass      (osc_ctrl[`CFS_B_XT2_BYP]),
		.selected    (xtal2_selected),
		.in_use      (xtal2_in_use),
		.osc_run     (x2_run)
	);

	// control registers, reserved bits held by the write masks, irq_mask reserved bits written as zero
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_ctrl <= `CFS_OSC_RESET;
			req_ctrl <= `CFS_REQ_RESET;
			irq_mask <= 16'h0000;
			warn_en <= 1'b0;
			fast_rst_en <= 1'b0;
		end else if (wr) begin
			osc_ctrl <= merge(avs_address, `CFS_IDX_OSC_CTRL, osc_ctrl,
			                  wdata, `CFS_OSC_WMASK);
			req_ctrl <= merge(avs_address, `CFS_IDX_REQ_CTRL, req_ctrl,
			                  wdata, `CFS_REQ_WMASK);
			if (avs_address == `CFS_IDX_IRQ_MASK)
				irq_mask <= {wdata[15:14], 9'h0, wdata[4:0]};
			warn_en <= fault_wr[`CFS_B_WARN_EN];
			fast_rst_en <= fault_wr[`CFS_B_FAST_RST_EN];
		end
	end

	// sticky flags: written zero clears, present condition sets again
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lock_loss_history <= 2'h3;
			lock_too_fast_flag <= 1'b0;
			xtal2_fault_flag <= 1'b0;
			xtal1_high_freq_fault_flag <= 1'b0;
			xtal1_low_freq_fault_flag <= 1'b1;
			digital_osc_fault_flag <= 1'b1;
		end else if (clk_en) begin
			lock_loss_history <= (lock_loss_history & fault_wr[11:10]) |
			                     {lock_too_fast, lock_too_low};
			lock_too_fast_flag <= (lock_too_fast_flag & fault_wr[4]) |
			        (lock_loss_now == `CFS_LOCK_FAST);
			xtal2_fault_flag <= (xtal2_fault_flag & fault_wr[3]) |
			                    xtal2_fault;
			xtal1_high_freq_fault_flag <=
			        (xtal1_high_freq_fault_flag & fault_wr[2]) |
			        (xtal1_fault && xtal1_high_freq);
			xtal1_low_freq_fault_flag <=
			        (xtal1_low_freq_fault_flag & fault_wr[1]) |
			        (xtal1_fault && !xtal1_high_freq);
			digital_osc_fault_flag <= (digital_osc_fault_flag &
			        fault_wr[0]) | tap_fault;
		end
	end

	// clock outputs and interrupt, all registered
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			xtal1_run <= 1'b0;
			xtal2_run <= 1'b0;
			xtal2_from_pin <= 1'b0;
			subsystem_clock_en <= 1'b0;
			module_osc_grant <= 1'b0;
			power_up_clear <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			xtal1_run <= x1_run;
			xtal2_run <= x2_run;
			xtal2_from_pin <= osc_ctrl[`CFS_B_XT2_BYP];
			// bit set means off; flipping polarity is a one-line change
			subsystem_clock_en <= !osc_ctrl[`CFS_B_SUBCLK_OFF];
			module_osc_grant <= module_osc_request &&
			        req_ctrl[`CFS_B_MOD_REQ_EN];
			power_up_clear <= lock_too_fast_flag && fast_rst_en;
			irq <= |(irq_status & irq_mask) ||
			       (osc_fault_summary_flag && irq_mask[15]);
		end
	end

	// avalon reads: one wait cycle, then data with waitrequest low
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_pending <= 1'b0;
			avs_readdata <= 32'h00000000;
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			avs_waitrequest <= 1'b1;
			rd_pending <= 1'b0;
			if (avs_write && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
			end else if (avs_read && !rd_pending && avs_waitrequest) begin
				rd_pending <= 1'b1;
				avs_waitrequest <= 1'b0;
				if (avs_address == `CFS_IDX_OSC_CTRL ||
				    avs_address == `CFS_IDX_OSC_CTRL_L ||
				    avs_address == `CFS_IDX_OSC_CTRL_H)
					avs_readdata <= {16'h0000,
					        pick(avs_address, `CFS_IDX_OSC_CTRL, osc_ctrl)};
				else if (avs_address == `CFS_IDX_FAULT ||
				         avs_address == `CFS_IDX_FAULT_L ||
				         avs_address == `CFS_IDX_FAULT_H)
					avs_readdata <= {16'h0000,
					        pick(avs_address, `CFS_IDX_FAULT, fault_word)};
				else if (avs_address == `CFS_IDX_REQ_CTRL ||
				         avs_address == `CFS_IDX_REQ_CTRL_L ||
				         avs_address == `CFS_IDX_REQ_CTRL_H)
					avs_readdata <= {16'h0000,
					        pick(avs_address, `CFS_IDX_REQ_CTRL, req_ctrl)};
				else if (avs_address == `CFS_IDX_IRQ_MASK)
					avs_readdata <= {16'h0000, irq_mask};
				else
					avs_readdata <= 32'h00000000; // unmapped reads zero
			end
		end
	end
endmodule // cfs_clock_fault

// ---- logic/cfs_defines.vh ----
// Purpose: offsets, field positions, reset values for clock fault block
// Assumes: Avalon-MM word bus, byte address = 4 * index
// Notes:   16-bit registers, high/low byte aliases at their own indexes
`ifndef CFS_DEFINES_VH
`define CFS_DEFINES_VH
// register indexes
`define CFS_IDX_OSC_CTRL    4'h0
`define CFS_IDX_FAULT       4'h1
`define CFS_IDX_REQ_CTRL    4'h2
`define CFS_IDX_OSC_CTRL_L  4'h3
`define CFS_IDX_OSC_CTRL_H  4'h4
`define CFS_IDX_FAULT_L     4'h5
`define CFS_IDX_FAULT_H     4'h6
`define CFS_IDX_REQ_CTRL_L  4'h7
`define CFS_IDX_REQ_CTRL_H  4'h8
`define CFS_IDX_IRQ_MASK    4'h9
// writable masks and reset values
`define CFS_OSC_WMASK       16'hd13f
`define CFS_OSC_RESET       16'hc1cd
`define CFS_FAULT_RESET     16'h0c03
`define CFS_REQ_WMASK       16'h031f
`define CFS_REQ_RESET       16'h0317
// field positions
`define CFS_B_XT2_OFF       8
`define CFS_B_XT2_BYP       12
`define CFS_B_XT1_BYP       4
`define CFS_B_SUBCLK_OFF    1
`define CFS_B_XT1_OFF       0
`define CFS_B_WARN_EN       13
`define CFS_B_FAST_RST_EN   12
`define CFS_B_MOD_REQ_EN    3
// lock state codes
`define CFS_LOCK_OK         2'h0
`define CFS_LOCK_LOW        2'h1
`define CFS_LOCK_FAST       2'h2
`define CFS_LOCK_ERR        2'h3
`define CFS_TAP_MAX         5'h1f
`endif

// ---- logic/cfs_osc_gate.v ----
// Purpose: decides whether one crystal oscillator runs
// Assumes: all inputs but the asynchronous rst_b synchronous to clk_sys
// Notes:   registered output, one cycle of latency
`timescale 1ns/10ps
module cfs_osc_gate (
	input  wire clk_sys,
	input  wire rst_b,
	input  wire clk_en,
	input  wire disable_bit,
	input  wire bypass,
	input  wire selected,
	input  wire in_use,
	output reg  osc_run
);
	wire next_osc_run;
	// bypass always wins; disable only stops an unused oscillator
	assign next_osc_run = !bypass && (disable_bit ? in_use
	                                              : (selected || in_use));
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			osc_run <= 1'b0;
		else if (clk_en)
			osc_run <= next_osc_run;
	end
endmodule // cfs_osc_gate

// ---- tb/cfs_checker.sv ----
// Purpose: port checks for the clock fault block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   latencies follow the registered outputs of the design
`timescale 1ns/10ps
module cfs_checker (
	input wire        clk_sys,
	input wire        rst_b,
	input wire        clk_en,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        xtal1_selected,
	input wire        xtal2_selected,
	input wire        xtal2_in_use,
	input wire        module_osc_request,
	input wire        xtal1_run,
	input wire        xtal2_run,
	input wire        xtal2_from_pin,
	input wire        module_osc_grant
);
	// reset aborts every attempt, so no stale history leaks across it
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	chk_wait_answer: assert property ((avs_read || avs_write) &&
		avs_waitrequest && clk_en |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	chk_wait_pulse: assert property (!avs_waitrequest && clk_en |=>
		avs_waitrequest) else $error("waitrequest low too long");
	chk_no_spurious: assert property (!avs_read && !avs_write &&
		avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	chk_upper_zero: assert property (
		!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_grant_off: assert property (
		!module_osc_request && clk_en |=> !module_osc_grant)
		else $error("grant without request");
	chk_xt2_in_use: assert property (
		(xtal2_in_use && xtal2_selected && !xtal2_from_pin && clk_en)[*2]
		|=> xtal2_run) else $error("used xtal2 stopped");
	// run outputs lag their inputs by two registers
	chk_xt2_unsel: assert property (
		(!xtal2_selected && !xtal2_in_use && clk_en)[*2] |=> !xtal2_run)
		else $error("unselected xtal2 runs");
	chk_xt1_unsel: assert property (
		(!xtal1_selected && clk_en)[*2] |=> !xtal1_run)
		else $error("unselected xtal1 runs");
endmodule // cfs_checker

// ---- tb/cfs_clock_fault_tb.sv ----
// Purpose: directed register and pin tests for the clock fault block
// Assumes: one wait cycle per access, inputs change after rising edges
// Notes:   an irq mask bit of one lets that flag reach irq
`timescale 1ns/10ps
`include "cfs_defines.vh"
module cfs_clock_fault_tb;
	reg         clk_sys, rst_b, clk_en, avs_read, avs_write;
	reg         xtal1_fault, xtal1_high_freq, xtal2_fault;
	reg         lock_too_low, lock_too_fast, module_osc_request;
	reg         xtal1_selected, xtal2_selected, xtal1_in_use, xtal2_in_use;
	reg  [3:0]  avs_address;
	reg  [31:0] avs_writedata;
	reg  [4:0]  digital_osc_tap;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest, xtal1_run, xtal2_run, xtal2_from_pin;
	wire        subsystem_clock_en, module_osc_grant, power_up_clear, irq;
	integer     cyc, fail_count, cmp_count;

	cfs_clock_fault cfs_clock_fault_inst (.clk_sys, .rst_b, .clk_en,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .xtal1_fault, .xtal1_high_freq, .xtal2_fault,
		.digital_osc_tap, .lock_too_low, .lock_too_fast, .xtal1_selected,
		.xtal2_selected, .xtal1_in_use, .xtal2_in_use, .module_osc_request,
		.xtal1_run, .xtal2_run, .xtal2_from_pin, .subsystem_clock_en,
		.module_osc_grant, .power_up_clear, .irq);

	// 25 ns period
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// hang guard, well above the roughly 175 cycles of tests
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			fail_count = fail_count + 1;
			results;
		end
	end

	task cmp(input [31:0] got, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task wr(input [3:0] a, input [15:0] d);
	begin
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= 1'b1;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		avs_write <= 1'b0;
		repeat (2) @(posedge clk_sys);
	end
	endtask

	// read, keep only the bits in m, compare with e
	task rc(input [3:0] a, input [15:0] m, input [15:0] e);
	begin
		repeat (2) @(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		cmp(avs_readdata & {16'h0000, m}, {16'h0000, e});
		avs_read <= 1'b0;
		@(posedge clk_sys);
	end
	endtask

	task results;
	begin
		$display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	// main sequence; reset held three cycles
	initial begin
		{rst_b, avs_read, avs_write, xtal1_fault, xtal1_high_freq} = 0;
		{xtal2_fault, lock_too_low, lock_too_fast, module_osc_request} = 0;
		{xtal1_selected, xtal2_selected, xtal1_in_use, xtal2_in_use} = 0;
		{avs_address, avs_writedata} = 0;
		{cyc, fail_count, cmp_count} = 0;
		clk_en = 1'b1;
		digital_osc_tap = 5'h0a;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rc(`CFS_IDX_OSC_CTRL, 16'hffff, 16'hc1cd);
		rc(`CFS_IDX_REQ_CTRL, 16'hffff, 16'h0317);
		rc(`CFS_IDX_FAULT, 16'h3f1f, 16'h0f03);
		cmp(subsystem_clock_en, 1);
		rc(4'hf, 16'hffff, 16'h0000);
		$display("reset test end");
		// byte aliases touch only their half; reserved bits keep their reset value
		xtal2_selected <= 1'b1;
		xtal1_selected <= 1'b1;
		wr(`CFS_IDX_OSC_CTRL_L, 16'h0002);
		rc(`CFS_IDX_OSC_CTRL, 16'hffff, 16'hc1c2);
		cmp(subsystem_clock_en, 0);
		wr(`CFS_IDX_OSC_CTRL_H, 16'h00ff);
		rc(`CFS_IDX_OSC_CTRL_H, 16'hffff, 16'h00d1);
		cmp(xtal2_from_pin, 1);
		cmp(xtal2_run, 0);
		wr(`CFS_IDX_OSC_CTRL, 16'h0000);
		rc(`CFS_IDX_OSC_CTRL, 16'hffff, 16'h00c0);
		cmp({xtal2_run, xtal1_run}, 3);
		wr(`CFS_IDX_OSC_CTRL, 16'h0101);
		repeat (2) @(posedge clk_sys);
		cmp({xtal2_run, xtal1_run}, 0);
		xtal1_in_use <= 1'b1;
		xtal2_in_use <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cmp({xtal2_run, xtal1_run}, 3);
		$display("osc test end");
		// module oscillator requests gated by the enable bit
		module_osc_request <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cmp(module_osc_grant, 0);
		wr(`CFS_IDX_REQ_CTRL, 16'h031f);
		rc(`CFS_IDX_REQ_CTRL, 16'hffff, 16'h031f);
		cmp(module_osc_grant, 1);
		// clock enable low freezes the grant
		clk_en <= 1'b0;
		module_osc_request <= 1'b0;
		repeat (3) @(posedge clk_sys);
		cmp(module_osc_grant, 1);
		clk_en <= 1'b1;
		repeat (2) @(posedge clk_sys);
		cmp(module_osc_grant, 0);
		module_osc_request <= 1'b1;
		wr(`CFS_IDX_REQ_CTRL_L, 16'h0017);
		rc(`CFS_IDX_REQ_CTRL, 16'hffff, 16'h0317);
		cmp(module_osc_grant, 0);
		$display("request test end");
		// tap limits, clearing while the fault persists
		wr(`CFS_IDX_IRQ_MASK, 16'h0000);
		wr(`CFS_IDX_FAULT, 16'h0000);
		rc(`CFS_IDX_FAULT, 16'h0f1f, 16'h0000);
		digital_osc_tap <= 5'h1f;
		rc(`CFS_IDX_FAULT, 16'h031f, 16'h0301);
		wr(`CFS_IDX_FAULT_L, 16'h0000);
		rc(`CFS_IDX_FAULT, 16'h031f, 16'h0301);
		digital_osc_tap <= 5'h00;
		wr(`CFS_IDX_FAULT, 16'h0000);
		rc(`CFS_IDX_FAULT, 16'h0301, 16'h0301);
		digital_osc_tap <= 5'h0a;
		wr(`CFS_IDX_FAULT, 16'h0000);
		lock_too_low <= 1'b1;
		rc(`CFS_IDX_FAULT, 16'h0f11, 16'h0500);
		lock_too_low <= 1'b0;
		rc(`CFS_IDX_FAULT, 16'h0f11, 16'h0400);
		lock_too_fast <= 1'b1;
		rc(`CFS_IDX_FAULT, 16'h0f11, 16'h0e10);
		cmp(power_up_clear, 0);
		wr(`CFS_IDX_FAULT, 16'h1c1f);
		cmp(power_up_clear, 1);
		lock_too_fast <= 1'b0;
		wr(`CFS_IDX_FAULT, 16'h0000);
		cmp(power_up_clear, 0);
		$display("lock test end");
		// xtal2 fault flag through irq via mask bit 3, masked then unmasked
		xtal2_fault <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cmp(irq, 0);
		wr(`CFS_IDX_IRQ_MASK, 16'h0008);
		cmp(irq, 1);
		xtal2_fault <= 1'b0;
		wr(`CFS_IDX_FAULT_L, 16'h00f7);
		rc(`CFS_IDX_FAULT, 16'h0008, 16'h0000);
		cmp(irq, 0);
		{xtal1_fault, xtal1_high_freq} <= 2'b11;
		rc(`CFS_IDX_FAULT, 16'h0006, 16'h0004);
		// history is clear, so only the summary path can raise irq with this mask
		wr(`CFS_IDX_IRQ_MASK, 16'h8000);
		cmp(irq, 1);
		$display("irq test end");
		results;
	end
endmodule // cfs_clock_fault_tb

bind cfs_clock_fault cfs_checker cfs_checker_inst (.clk_sys, .rst_b,
	.clk_en, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.xtal1_selected, .xtal2_selected, .xtal2_in_use, .module_osc_request,
	.xtal1_run, .xtal2_run, .xtal2_from_pin, .module_osc_grant);
